//--- logic/dual_timer_pkg.sv
// Purpose: Shared constants and types for the dual timer reload block
// Assumes: 8-bit registers on a plain strobe port, one 200 MHz clock
// Notes:   Offsets are byte indexes of the banked register space
`default_nettype none
package dual_timer_pkg;
   localparam int            ADDR_W          = 8;
   localparam int            DATA_W          = 8;
   localparam logic [7:0]    OFS_CONTROL     = 8'h00;
   localparam logic [7:0]    OFS_LOW_PHASE   = 8'h04;
   localparam logic [7:0]    OFS_HIGH_PHASE  = 8'h05;
   localparam logic [7:0]    OFS_RELOAD_LOW  = 8'h06;
   localparam logic [7:0]    OFS_RELOAD_HIGH = 8'h07;
   localparam logic [7:0]    OFS_IRQ_STATUS  = 8'h10;
   localparam logic [7:0]    OFS_IRQ_MASK    = 8'h11;
   localparam int            BIT_RUN         = 7;
   localparam int            BIT_SINGLE      = 6;
   localparam int            BIT_TIMEOUT     = 5;
   localparam int            BIT_CLKSEL_LO   = 3;
   localparam int            BIT_CAPT_IE     = 2;
   localparam int            BIT_TIMEOUT_IE  = 1;
   localparam int            BIT_PIN_SELECT  = 0;
   localparam logic [7:0]    CONTROL_RESET   = 8'h00;
   localparam logic [7:0]    HOLD_RESET      = 8'h00;
   localparam logic [7:0]    UNMAPPED_READ   = 8'h00;
   // Event bit positions in the interrupt status and mask registers
   localparam int            EVT_TIMEOUT     = 0;
   localparam int            EVT_WRAP        = 1;
   localparam int            EVT_N           = 2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_COUNT = 2'b11
   } count_state_t;
endpackage
`default_nettype wire

//--- logic/prescale_if.sv
// Purpose: Carries the prescaler selection and its tick between modules
// Assumes: One clock domain
// Notes:   Tick is a one-cycle enable
`default_nettype none
interface prescale_if;
   logic [1:0] select;
   logic       tick;
   modport owner  (output select, input tick);
   modport scaler (input select, output tick);
endinterface
`default_nettype wire

//--- logic/clock_prescaler.sv
// Purpose: Divides the system clock by 1, 2, 4 or 8 as a tick enable
// Assumes: Synchronised active-low reset already released cleanly
// Notes:   A change of selection takes effect on the free-running count
`default_nettype none
module clock_prescaler (
   input  wire logic  clk,      // System clock
   input  wire logic  rstN,     // Synchronised reset, active low
   prescale_if.scaler ps        // Selection in, tick out
);
   logic [2:0] divCount;

   // Free-running divider; no reload keeps the tick phase stable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         divCount <= 3'h0;
      end else begin
         divCount <= divCount + 3'h1;
      end
   end

   // Tick when the low bits selected by the divide ratio are all ones
   always_comb begin
      unique case (ps.select)
         2'b00: ps.tick = 1'b1;
         2'b01: ps.tick = divCount[0];
         2'b10: ps.tick = &divCount[1:0];
         2'b11: ps.tick = &divCount;
      endcase
   end
endmodule
`default_nettype wire

//--- logic/dual_timer_reload.sv
// Purpose: Reload/hold registers and byte counter control for two timers
// Assumes: Software is the only master; inputs synchronous to clk
// Notes:   Hold registers and the interrupt gate are kept on stop recovery
`default_nettype none
module dual_timer_reload
   import dual_timer_pkg::*;
(
   input  wire logic                          clk,          // 200 MHz clock
   input  wire logic                          nrst,         // Async reset
   input  wire logic                          stopRecovery, // Stop recovery
   input  wire logic [dual_timer_pkg::ADDR_W-1:0] addr,     // Reg address
   input  wire logic [dual_timer_pkg::DATA_W-1:0] wrData,   // Write data
   input  wire logic                          wrStb,        // Write strobe
   input  wire logic                          rdStb,        // Read strobe
   input  wire logic                          portData,     // Port latch bit
   output logic [dual_timer_pkg::DATA_W-1:0]  rdData,       // Read data
   output logic [15:0]                        wideReload,   // 16-bit reload
   output logic                               byteCounterOutput, // Level
   output logic                               pinOut,       // Port pin drive
   output logic                               timeoutIrq,   // Gated time-out
   output logic                               irq           // Summary irq
);
   import dual_timer_pkg::*;

   logic        rstSync1;
   logic        rstN;
   logic [7:0]  reloadHighByte;
   logic [7:0]  reloadLowByte;
   logic [7:0]  highPhaseCount;
   logic [7:0]  lowPhaseCount;
   logic        byteCounterRun;
   logic        singlePass;
   logic        timeoutFlag;
   logic [1:0]  clockSelect;
   logic        captureIntEnable;
   logic        timeoutIntEnable;
   logic        pinOutputSelect;
   logic [7:0]  byteCount;
   logic        terminal;
   logic        wrap;
   logic [EVT_N-1:0] irqStatus;
   logic [EVT_N-1:0] irqMask;
   logic [EVT_N-1:0] events;
   count_state_t     state;
   logic [7:0]  controlView;
   logic [7:0]  readMux;
   prescale_if  ps ();

   // Reset released through two flops so removal is clean
   // Only the second flop is read by the logic below
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1 <= 1'b0;
         rstN     <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstN     <= rstSync1;
      end
   end

   // Divider selection comes straight from the control field
   assign ps.select = clockSelect;

   // Shared tick source; the counter only moves on a tick
   clock_prescaler u_prescaler (
      .clk  (clk),
      .rstN (rstN),
      .ps   (ps)
   );

   // Hold registers: only a full reset clears them, not stop recovery
   // A write lands on the edge after the strobe; reads see it next
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         reloadHighByte <= HOLD_RESET;
         reloadLowByte  <= HOLD_RESET;
         highPhaseCount <= HOLD_RESET;
         lowPhaseCount  <= HOLD_RESET;
      end else if (wrStb) begin
         unique case (addr)
            OFS_RELOAD_HIGH: reloadHighByte <= wrData;
            OFS_RELOAD_LOW:  reloadLowByte  <= wrData;
            OFS_HIGH_PHASE:  highPhaseCount <= wrData;
            OFS_LOW_PHASE:   lowPhaseCount  <= wrData;
            default: ;
         endcase
      end
   end

   // Wide counter takes its reload value as one word
   // Registered so both bytes reach the wide counter in the same cycle
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wideReload <= 16'h0000;
      end else begin
         wideReload <= {reloadHighByte, reloadLowByte};
      end
   end

   // Control bits; the interrupt gate deliberately ignores stop recovery
   // Capture enable is only stored; its capture path is not in this block
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         singlePass       <= 1'b0;
         clockSelect      <= 2'h0;
         captureIntEnable <= 1'b0;
         timeoutIntEnable <= 1'b0;
         pinOutputSelect  <= 1'b0;
      end else if (wrStb && addr == OFS_CONTROL) begin
         singlePass       <= wrData[BIT_SINGLE];
         clockSelect      <= wrData[BIT_CLKSEL_LO +: 2];
         captureIntEnable <= wrData[BIT_CAPT_IE];
         timeoutIntEnable <= wrData[BIT_TIMEOUT_IE];
         pinOutputSelect  <= wrData[BIT_PIN_SELECT];
      end else if (stopRecovery) begin
         pinOutputSelect  <= 1'b0;
      end
   end

   // Run bit: software sets it; single pass drops it at terminal count
   // A software write wins over a same-cycle single-pass stop
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         byteCounterRun <= 1'b0;
      end else if (wrStb && addr == OFS_CONTROL) begin
         byteCounterRun <= wrData[BIT_RUN];
      end else if (terminal && singlePass) begin
         byteCounterRun <= 1'b0;
      end else if (stopRecovery) begin
         byteCounterRun <= 1'b0;
      end
   end

   // Time-out flag: set wins over a same-cycle write-one clear
   // Writing zero, as a masked read-modify-write does, leaves it alone
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         timeoutFlag <= 1'b0;
      end else if (terminal) begin
         timeoutFlag <= 1'b1;
      end else if (wrStb && addr == OFS_CONTROL && wrData[BIT_TIMEOUT]) begin
         timeoutFlag <= 1'b0;
      end
   end

   // Terminal needs the run bit too: the state lags a stop write by one
   // cycle, and a stopped counter must not raise the time-out flag
   assign terminal = byteCounterRun && (state == ST_COUNT) && ps.tick
                     && byteCount == 8'h01;
   // Wrap is the modulo flavour of a terminal count
   assign wrap     = terminal && !singlePass;

   // Phase counter: loads the count matching the present output level
   // The level starts low, so a fresh start counts the low phase first
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state             <= ST_IDLE;
         byteCount         <= 8'h00;
         byteCounterOutput <= 1'b0;
      end else if (!byteCounterRun) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               state <= ST_LOAD;
            end
            ST_LOAD: begin
               byteCount <= byteCounterOutput ? highPhaseCount
                                              : lowPhaseCount;
               state     <= ST_COUNT;
            end
            ST_COUNT: begin
               if (terminal) begin
                  byteCounterOutput <= ~byteCounterOutput;
                  state <= singlePass ? ST_IDLE : ST_LOAD;
               end else if (ps.tick) begin
                  byteCount <= byteCount - 8'h01;
               end
            end
            // Code 2'b10 is unused; fall back to idle if it ever appears
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Pin mux registered so the pin changes one cycle after the level
   // Trade-off: one cycle of lag buys a glitch-free pin
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pinOut <= 1'b0;
      end else begin
         pinOut <= pinOutputSelect ? byteCounterOutput
                                   : portData;
      end
   end

   // Gated time-out interrupt follows the flag while enabled
   // Terminal is ORed in so the interrupt does not lag the flag
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         timeoutIrq <= 1'b0;
      end else begin
         timeoutIrq <= timeoutIntEnable
                       && (timeoutFlag || terminal);
      end
   end

   // Event sources for the sticky status bits
   assign events[EVT_TIMEOUT] = terminal;
   assign events[EVT_WRAP]    = wrap;

   // Sticky status, cleared by reading it; a new event wins the race
   // Losing an event to a read would hide a terminal count from software
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         irqStatus <= '0;
      end else if (rdStb && addr == OFS_IRQ_STATUS) begin
         irqStatus <= events;
      end else begin
         irqStatus <= irqStatus | events;
      end
   end

   // Interrupt mask, same layout as the status register
   // Unused upper bits are not stored and read back as zero
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         irqMask <= '0;
      end else if (wrStb && addr == OFS_IRQ_MASK) begin
         irqMask <= wrData[EVT_N-1:0];
      end
   end

   // Level interrupt from the next status value, so it leaves a flop
   // Computing from the next value avoids a cycle of extra latency
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         irq <= 1'b0;
      end else if (rdStb && addr == OFS_IRQ_STATUS) begin
         irq <= |(events & irqMask);
      end else begin
         irq <= |((irqStatus | events) & irqMask);
      end
   end

   // Control read view assembled from the shared field positions
   always_comb begin
      controlView                     = 8'h00;
      controlView[BIT_RUN]            = byteCounterRun;
      controlView[BIT_SINGLE]         = singlePass;
      controlView[BIT_TIMEOUT]        = timeoutFlag;
      controlView[BIT_CLKSEL_LO +: 2] = clockSelect;
      controlView[BIT_CAPT_IE]        = captureIntEnable;
      controlView[BIT_TIMEOUT_IE]     = timeoutIntEnable;
      controlView[BIT_PIN_SELECT]     = pinOutputSelect;
   end

   // Read multiplexer; unmapped offsets read as a fixed value
   always_comb begin
      unique case (addr)
         OFS_CONTROL:     readMux = controlView;
         OFS_LOW_PHASE:   readMux = lowPhaseCount;
         OFS_HIGH_PHASE:  readMux = highPhaseCount;
         OFS_RELOAD_LOW:  readMux = reloadLowByte;
         OFS_RELOAD_HIGH: readMux = reloadHighByte;
         OFS_IRQ_STATUS:  readMux = {{(8-EVT_N){1'b0}}, irqStatus};
         OFS_IRQ_MASK:    readMux = {{(8-EVT_N){1'b0}}, irqMask};
         default:         readMux = UNMAPPED_READ;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise, so a stale
   // value never lingers on the bus between reads
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdData <= 8'h00;
      end else if (rdStb) begin
         rdData <= readMux;
      end else begin
         rdData <= 8'h00;
      end
   end
endmodule
`default_nettype wire

//--- tb/dual_timer_reload_assertions.sv
// Purpose: Port assertions for the dual timer reload block
// Assumes: No bus traffic during the reset synchroniser delay
// Notes:   Shadows follow control bits 0 and 1 as written on the bus
`default_nettype none
module dual_timer_reload_assertions
   import dual_timer_pkg::*;
(
   input wire logic                           clk,          // Clock
   input wire logic                           nrst,         // Async reset
   input wire logic                           stopRecovery, // Stop recovery
   input wire logic [dual_timer_pkg::ADDR_W-1:0] addr,      // Address
   input wire logic [dual_timer_pkg::DATA_W-1:0] wrData,    // Write data
   input wire logic                           wrStb,        // Write strobe
   input wire logic                           rdStb,        // Read strobe
   input wire logic                           portData,     // Port latch
   input wire logic [dual_timer_pkg::DATA_W-1:0] rdData,    // Read data
   input wire logic [15:0]                    wideReload,   // Wide reload
   input wire logic                           byteCounterOutput, // Level
   input wire logic                           pinOut,       // Pin drive
   input wire logic                           timeoutIrq    // Gated irq
);
   logic [1:0] live;
   logic       sel;
   logic       ie;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Settle count: the synchroniser hides the first edges after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) live <= 2'h0;
      else if (live != 2'h3) live <= live + 2'h1;
   end
   // Shadow of pin select and gate; stop recovery drops the select only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel <= 1'b0;
         ie  <= 1'b0;
      end else if (wrStb && addr == OFS_CONTROL) begin
         sel <= wrData[BIT_PIN_SELECT];
         ie  <= wrData[BIT_TIMEOUT_IE];
      end else if (stopRecovery) begin
         sel <= 1'b0;
      end
   end
   property p_wide_high;
      wrStb && addr == OFS_RELOAD_HIGH
         |-> ##2 wideReload[15:8] == $past(wrData, 2);
   endproperty
   a_wide_high: assert property (p_wide_high)
      else $error("wide high byte not applied");
   property p_wide_low;
      wrStb && addr == OFS_RELOAD_LOW
         |-> ##2 wideReload[7:0] == $past(wrData, 2);
   endproperty
   a_wide_low: assert property (p_wide_low)
      else $error("wide low byte not applied");
   property p_low_readback;
      rdStb && addr == OFS_RELOAD_LOW |=> rdData == wideReload[7:0];
   endproperty
   a_low_readback: assert property (p_low_readback)
      else $error("wide low readback differs");
   property p_high_phase;
      wrStb && addr == OFS_HIGH_PHASE ##1 rdStb && addr == OFS_HIGH_PHASE
         |=> rdData == $past(wrData, 2);
   endproperty
   a_high_phase: assert property (p_high_phase)
      else $error("high phase readback differs");
   property p_low_phase;
      wrStb && addr == OFS_LOW_PHASE ##1 rdStb && addr == OFS_LOW_PHASE
         |=> rdData == $past(wrData, 2);
   endproperty
   a_low_phase: assert property (p_low_phase)
      else $error("low phase readback differs");
   property p_hold_stop;
      stopRecovery && !wrStb && !$past(wrStb) |=> $stable(wideReload);
   endproperty
   a_hold_stop: assert property (p_hold_stop)
      else $error("reload lost on stop recovery");
   property p_ie_gate;
      !ie && !$past(ie) |-> !timeoutIrq;
   endproperty
   a_ie_gate: assert property (p_ie_gate)
      else $error("time-out irq not gated");
   property p_pin;
      live == 2'h3 |=> pinOut == ($past(sel) ? $past(byteCounterOutput)
                                              : $past(portData));
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin routing wrong");
   c_pin: cover property (sel && byteCounterOutput);
   c_irq: cover property (timeoutIrq);
   c_stop: cover property (stopRecovery);
endmodule
bind dual_timer_reload dual_timer_reload_assertions i_chk (.clk, .nrst,
   .stopRecovery, .addr, .wrData, .wrStb, .rdStb, .portData, .rdData,
   .wideReload, .byteCounterOutput, .pinOut, .timeoutIrq);
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench for the dual timer reload block
// Assumes: Small phase counts so terminal counts come quickly
// Notes:   Strobes last one cycle; back to back where tasks chain
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import dual_timer_pkg::*;
   logic        clk, nrst, stopRecovery, wrStb, rdStb, portData;
   logic [7:0]  addr, wrData, rdData, d;
   logic [15:0] wideReload;
   logic        byteCounterOutput, pinOut, timeoutIrq, irq;
   int          error_cnt, samples_checked, n;
   dual_timer_reload i_dut (.clk, .nrst, .stopRecovery, .addr, .wrData,
      .wrStb, .rdStb, .portData, .rdData, .wideReload, .byteCounterOutput,
      .pinOut, .timeoutIrq, .irq);
   // Free-running 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic wrap_up;
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, e, input string m);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // Strobe stays up until the next bus call or idle drops it
   task automatic op(input logic w, input logic [7:0] a, dat);
      @(posedge clk);
      wrStb  <= w;
      rdStb  <= !w;
      addr   <= a;
      wrData <= dat;
   endtask
   task automatic idle;
      @(posedge clk);
      wrStb <= 1'b0;
      rdStb <= 1'b0;
   endtask
   // Read data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a);
      op(1'b0, a, 8'h00);
      idle();
      #1 d = rdData;
   endtask
   // Bounded wait; an expired wait ends the run as a failure
   task automatic wait_hi(input logic useIrq);
      n = 0;
      while ((useIrq ? irq : timeoutIrq) !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 200) begin
         $display("[ERR] %0t wait expired", $time);
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic t_reset;
      logic [7:0] ofs [6] = '{OFS_CONTROL, OFS_LOW_PHASE, OFS_HIGH_PHASE,
                              OFS_RELOAD_LOW, OFS_RELOAD_HIGH, 8'h20};
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i]);
         chk(d, 8'h00, "reset value");
      end
   endtask
   task automatic t_regs;
      logic [7:0] ofs [4] = '{OFS_RELOAD_HIGH, OFS_RELOAD_LOW,
                              OFS_HIGH_PHASE, OFS_LOW_PHASE};
      logic [7:0] val [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
      for (int i = 0; i < 4; i++) begin
         op(1'b1, ofs[i], val[i]);
         rd(ofs[i]);
         chk(d, val[i], "readback");
      end
      chk(wideReload[15:8], 8'hA5, "wide high");
      chk(wideReload[7:0], 8'h5A, "wide low");
      op(1'b1, 8'h20, 8'h77);
      rd(8'h20);
      chk(d, UNMAPPED_READ, "unmapped read");
      rd(OFS_LOW_PHASE);
      chk(d, 8'h01, "aliased write");
   endtask
   // Stop recovery keeps holds and the gate but drops the pin select
   task automatic t_stop;
      op(1'b1, OFS_CONTROL, 8'h03);
      portData <= 1'b1;
      idle();
      repeat (2) @(posedge clk);
      #1 chk({7'h00, pinOut}, 8'h00, "pin routed");
      @(posedge clk);
      stopRecovery <= 1'b1;
      @(posedge clk);
      stopRecovery <= 1'b0;
      rd(OFS_CONTROL);
      chk(d, 8'h02, "control after stop");
      chk({7'h00, pinOut}, 8'h01, "pin back to port");
      rd(OFS_RELOAD_HIGH);
      chk(d, 8'hA5, "hold after stop");
      chk(wideReload[7:0], 8'h5A, "wide after stop");
   endtask
   task automatic t_count;
      op(1'b1, OFS_LOW_PHASE, 8'h03);
      op(1'b1, OFS_HIGH_PHASE, 8'h02);
      op(1'b1, OFS_CONTROL, 8'h20);
      op(1'b1, OFS_CONTROL, 8'h83);
      idle();
      wait_hi(1'b0);
      chk(n[7:0], 8'h05, "low phase length");
      chk({7'h00, byteCounterOutput}, 8'h01, "output toggled");
      op(1'b1, OFS_CONTROL, 8'h03);
      rd(OFS_CONTROL);
      chk(d, 8'h23, "flag kept on zero");
      op(1'b1, OFS_CONTROL, 8'h23);
      rd(OFS_CONTROL);
      chk(d, 8'h03, "flag cleared");
      chk({7'h00, timeoutIrq}, 8'h00, "irq after clear");
   endtask
   // Single pass stops itself; status read clears, mask gates irq
   task automatic t_single;
      rd(OFS_IRQ_STATUS);
      chk(d, 8'h03, "status sticky");
      op(1'b1, OFS_IRQ_MASK, 8'h01);
      op(1'b1, OFS_CONTROL, 8'hC0);
      idle();
      wait_hi(1'b1);
      chk(n[7:0], 8'h04, "high phase length");
      rd(OFS_CONTROL);
      chk(d, 8'h60, "single pass stop");
      rd(OFS_IRQ_STATUS);
      chk(d, 8'h01, "status bit");
      @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00, "irq after status read");
      op(1'b1, OFS_IRQ_MASK, 8'h00);
      op(1'b1, OFS_CONTROL, 8'h20);
      op(1'b1, OFS_CONTROL, 8'hD8);
      idle();
      repeat (6) @(posedge clk);
      rd(OFS_CONTROL);
      chk(d, 8'hD8, "divided clock still counting");
      repeat (40) @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00, "masked irq");
      rd(OFS_CONTROL);
      chk(d, 8'h78, "second pass");
   endtask
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk);
      $display("[ERR] %0t run timed out", $time);
      error_cnt++;
      wrap_up();
   end
   initial begin
      nrst = 1'b0;
      stopRecovery = 1'b0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      portData = 1'b0;
      addr = 8'h00;
      wrData = 8'h00;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_regs();
      t_stop();
      t_count();
      t_single();
      wrap_up();
   end
endmodule
`default_nettype wire
